// ---- hw/sspf_regs.vh ----
`ifndef SSPF_REGS_VH
`define SSPF_REGS_VH

// ****************************************************************
// frame geometry of the slot serial link
// ****************************************************************
`define SSPF_FRAME_BITS     18'h24000
`define SSPF_FRAME_LAST     18'h23FFF
`define SSPF_SYNC_BITS      18'h00020
`define SSPF_BLOCK_COUNT    14'h2400
`define SSPF_PHASE_W        4
`define SSPF_SLOT_COUNT     5'h10
`define SSPF_FRAME_MS       24

// ****************************************************************
// user byte path
// ****************************************************************
`define SSPF_BYTE_W         8
`define SSPF_BYTE_LAST      4'h7
`define SSPF_BUF_DEPTH      2

`endif

// ---- hw/sspf_buf2.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sspf_regs.vh"

module sspf_buf2 (
	input  wire                     i_clk_sys,
	input  wire                     i_srst,
	input  wire [`SSPF_BYTE_W-1:0]  i_data,
	input  wire                     i_valid,
	output wire                     o_ready,
	output wire [`SSPF_BYTE_W-1:0]  o_data,
	output wire                     o_valid,
	input  wire                     i_ready
);

	// ****************************************************************
	// two-entry storage
	// ****************************************************************
	reg [`SSPF_BYTE_W-1:0] mem_reg [0:`SSPF_BUF_DEPTH-1];
	reg                    wr_ptr_reg;
	reg                    rd_ptr_reg;
	reg [1:0]              cnt_reg;
	wire                   push;
	wire                   pop;

	// full and empty come straight from the fill count
	assign o_ready = (cnt_reg != 2'h2);
	assign o_valid = (cnt_reg != 2'h0);
	assign o_data  = mem_reg[rd_ptr_reg];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// pointers and fill count; push and pop may share a cycle
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg    <= 2'h0;
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= i_data;
				wr_ptr_reg          <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 2'h1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 2'h1;
		end
	end

endmodule // sspf_buf2

`default_nettype wire

// ---- hw/sspf_framer.v ----
// Operation
// - we drive 6144 kHz downstream bit clock
// - downstream sync rises every 147456 clock periods
// - downstream sync high for 32 clock periods
// - downstream sync changes on clock falling edges
// - exactly 147456 data bits per frame
// - data stable at downstream clock rising edge
// - frame is 9216 blocks of sixteen phases
// - phase 0 block 0 starts with sync
// - sixteen 384 kbit/s slots, one phase each
// - slot equals bit-reversed phase plus one
// - drive downstream lines, accept upstream reference lines
// - forward received reference or substitute our own
// - forward data, add or overwrite one slot
`timescale 1ns/1ps
`default_nettype none
`include "sspf_regs.vh"

module sspf_framer (
	input  wire                     i_clk_sys,
	input  wire                     i_srst,
	// upstream reference from the receiver (pins)
	input  wire                     i_upstream_ref_clock,
	input  wire                     i_upstream_ref_frame_sync,
	// received downstream data of the previous ring member (pin)
	input  wire                     i_rx_data,
	// our own reference, used when substituting (pins)
	input  wire                     i_local_ref_clock,
	input  wire                     i_local_ref_frame_sync,
	// reference repeated toward the previous ring member
	output reg                      o_fwd_ref_clock,
	output reg                      o_fwd_ref_frame_sync,
	// downstream lines
	output reg                      o_downstream_bit_clock,
	output reg                      o_downstream_frame_sync,
	output reg                      o_data,
	// controls
	input  wire                     i_ref_own,
	input  wire                     i_add_en,
	input  wire [4:0]               i_add_slot,
	// user byte stream for the added slot
	input  wire [`SSPF_BYTE_W-1:0]  i_tx_data,
	input  wire                     i_tx_valid,
	output wire                     o_tx_ready,
	// status
	output reg  [3:0]               o_phase,
	output reg  [4:0]               o_slot,
	output reg                      o_locked,
	output reg                      o_resync,
	output reg                      o_underflow
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	reg [4:0] meta_reg;
	reg [4:0] sync_reg;
	reg       clk_d_reg;
	wire      clk_s;
	wire      fsync_s;
	wire      rx_s;
	wire      lclk_s;
	wire      lsync_s;

	// first stage feeds only the second stage
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			meta_reg <= 5'h00;
			sync_reg <= 5'h00;
		end else begin
			meta_reg <= {i_local_ref_frame_sync, i_local_ref_clock, i_rx_data,
				i_upstream_ref_frame_sync, i_upstream_ref_clock};
			sync_reg <= meta_reg;
		end
	end

	assign clk_s   = sync_reg[0];
	assign fsync_s = sync_reg[1];
	assign rx_s    = sync_reg[2];
	assign lclk_s  = sync_reg[3];
	assign lsync_s = sync_reg[4];

	// ****************************************************************
	// edge detection on the received reference clock
	// ****************************************************************
	wire fall;
	wire rise;

	assign fall = clk_d_reg & ~clk_s;
	assign rise = ~clk_d_reg & clk_s;

	// ****************************************************************
	// bit counter locked to the reference sync
	// ****************************************************************
	reg  [17:0] cnt_reg;
	reg  [17:0] cnt_next;
	reg         fsync_prev_reg;
	reg         framed_reg;
	reg         rx_bit_reg;
	wire        sync_rise;
	wire [3:0]  phase_next;
	wire [4:0]  slot_next;

	// reference sync was sampled at our own previous falling edge
	assign sync_rise = fsync_s & ~fsync_prev_reg;

	// a reference rising sync restarts the frame; otherwise wrap at frame end
	always @* begin
		if (sync_rise)
			cnt_next = 18'h00000;
		else if (cnt_reg == `SSPF_FRAME_LAST)
			cnt_next = 18'h00000;
		else
			cnt_next = cnt_reg + 18'h00001;
	end

	// low four bits are the block phase; upper bits count 9216 blocks
	assign phase_next = cnt_next[`SSPF_PHASE_W-1:0];
	// slot is the phase read backwards, numbered from one
	assign slot_next  = {1'b0, phase_next[0], phase_next[1], phase_next[2],
		phase_next[3]} + 5'h01;

	// ****************************************************************
	// added slot byte path
	// ****************************************************************
	wire [`SSPF_BYTE_W-1:0] buf_data;
	wire                    buf_valid;
	wire                    buf_pop;
	wire                    slot_hit;
	reg  [`SSPF_BYTE_W-1:0] sh_reg;
	reg  [3:0]              left_reg;

	// one bit of the chosen slot per block; a byte spans eight blocks
	assign slot_hit = i_add_en & (slot_next == i_add_slot);
	assign buf_pop  = fall & slot_hit & (left_reg == 4'h0);

	// the slow drain stalls the buffer, so o_tx_ready throttles the user
	sspf_buf2 u_buf (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_data    (i_tx_data),
		.i_valid   (i_tx_valid),
		.o_ready   (o_tx_ready),
		.o_data    (buf_data),
		.o_valid   (buf_valid),
		.i_ready   (buf_pop)
	);

	// ****************************************************************
	// downstream sync and data updated at the reference falling edge; bit clock copied every cycle
	// ****************************************************************
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			clk_d_reg               <= 1'b0;
			o_downstream_bit_clock  <= 1'b0;
			o_downstream_frame_sync <= 1'b0;
			o_data                  <= 1'b0;
			cnt_reg                 <= 18'h00000;
			fsync_prev_reg          <= 1'b0;
			framed_reg              <= 1'b0;
			rx_bit_reg              <= 1'b0;
			sh_reg                  <= 8'h00;
			left_reg                <= 4'h0;
			o_phase                 <= 4'h0;
			o_slot                  <= 5'h01;
			o_locked                <= 1'b0;
			o_resync                <= 1'b0;
			o_underflow             <= 1'b0;
		end else begin
			clk_d_reg              <= clk_s;
			// clock follows the reference, same latency as sync and data
			o_downstream_bit_clock <= clk_s;
			o_resync               <= 1'b0;
			o_underflow            <= 1'b0;
			// received data is taken where its sender holds it stable
			if (rise)
				rx_bit_reg <= rx_s;
			if (fall) begin
				fsync_prev_reg <= fsync_s;
				cnt_reg        <= cnt_next;
				o_phase        <= phase_next;
				o_slot         <= slot_next;
				// no sync leaves before the first reference sync, else it rises off phase 0
				if (sync_rise)
					framed_reg <= 1'b1;
				// sync and data change with the clock fall: stable at rise
				o_downstream_frame_sync <= (sync_rise | framed_reg) &
					(cnt_next < `SSPF_SYNC_BITS);
				// a sync off the expected frame position costs lock
				if (sync_rise) begin
					o_locked <= (cnt_reg == `SSPF_FRAME_LAST);
					o_resync <= (cnt_reg != `SSPF_FRAME_LAST);
				end
				if (slot_hit && left_reg != 4'h0) begin
					o_data   <= sh_reg[`SSPF_BYTE_W-1];
					sh_reg   <= {sh_reg[`SSPF_BYTE_W-2:0], 1'b0};
					left_reg <= left_reg - 4'h1;
				end else if (slot_hit && buf_valid) begin
					o_data   <= buf_data[`SSPF_BYTE_W-1];
					sh_reg   <= {buf_data[`SSPF_BYTE_W-2:0], 1'b0};
					left_reg <= `SSPF_BYTE_LAST;
				end else begin
					// other slots, or an empty buffer, pass the ring through
					o_data      <= rx_bit_reg;
					o_underflow <= slot_hit;
				end
			end
		end
	end

	// ****************************************************************
	// reference repeated upstream: forwarded or our own
	// ****************************************************************
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_fwd_ref_clock      <= 1'b0;
			o_fwd_ref_frame_sync <= 1'b0;
		end else if (i_ref_own) begin
			o_fwd_ref_clock      <= lclk_s;
			o_fwd_ref_frame_sync <= lsync_s;
		end else begin
			o_fwd_ref_clock      <= clk_s;
			o_fwd_ref_frame_sync <= fsync_s;
		end
	end

endmodule // sspf_framer

`default_nettype wire

// ---- dv/sspf_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// framer port checker
// ****
module sspf_monitor (
	input	wire logic		i_clk_sys,
	input	wire logic		i_srst,
	input	wire logic		i_upstream_ref_clock,
	input	wire logic		i_local_ref_clock,
	input	wire logic		i_ref_own,
	input	wire logic		o_fwd_ref_clock,
	input	wire logic		o_downstream_bit_clock,
	input	wire logic		o_downstream_frame_sync,
	input	wire logic		o_data,
	input	wire logic [3:0]	o_phase,
	input	wire logic [4:0]	o_slot
);
	logic		clk_q_reg;
	logic		sync_q_reg;
	logic		own_q_reg;
	logic [7:0]	high_cnt_reg;
	logic [2:0]	calm_reg;
	wire		bit_fall = clk_q_reg & ~o_downstream_bit_clock;
	// a mode change seen this edge is not calm yet: the outputs still show the old mode
	wire		calm = (calm_reg == 3'h7) && (own_q_reg == i_ref_own);
	// edge history; calm waits out the synchronisers after reset or a mode change
	always_ff @(posedge i_clk_sys) begin
		clk_q_reg <= o_downstream_bit_clock;
		sync_q_reg <= o_downstream_frame_sync;
		own_q_reg <= i_ref_own;
		if (i_srst | (own_q_reg ^ i_ref_own)) calm_reg <= 3'h0;
		else if (!calm) calm_reg <= calm_reg + 3'h1;
		if (i_srst) high_cnt_reg <= 8'h00;
		else if (bit_fall) high_cnt_reg <= o_downstream_frame_sync ? high_cnt_reg + 8'h01 : 8'h00;
	end
	default clocking dcb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	sequence fall_s;
		$fell(o_downstream_bit_clock);
	endsequence
	sync_edge_a: assert property (!$stable(o_downstream_frame_sync) |-> fall_s)
		else $error("frame sync moved away from a clock fall");
	data_edge_a: assert property (!$stable(o_data) |-> fall_s)
		else $error("data moved away from a clock fall");
	sync_phase_a: assert property ($rose(o_downstream_frame_sync) |-> o_phase == 4'h0)
		else $error("frame sync rose off phase zero");
	slot_map_a: assert property (o_slot == {1'b0, o_phase[0], o_phase[1], o_phase[2], o_phase[3]} + 5'h01)
		else $error("slot does not match phase");
	sync_width_a: assert property (bit_fall && sync_q_reg && !o_downstream_frame_sync |-> high_cnt_reg == 8'h20)
		else $error("frame sync width wrong");
	clk_follow_a: assert property (calm |-> o_downstream_bit_clock == $past(i_upstream_ref_clock, 3))
		else $error("bit clock not following reference");
	fwd_own_a: assert property (calm && i_ref_own |-> o_fwd_ref_clock == $past(i_local_ref_clock, 3))
		else $error("own reference not forwarded");
	fwd_pass_a: assert property (calm && !i_ref_own |-> o_fwd_ref_clock == $past(i_upstream_ref_clock, 3))
		else $error("received reference not forwarded");
endmodule // sspf_monitor
bind sspf_framer sspf_monitor u_mon (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_upstream_ref_clock(i_upstream_ref_clock),
	.i_local_ref_clock(i_local_ref_clock), .i_ref_own(i_ref_own), .o_fwd_ref_clock(o_fwd_ref_clock),
	.o_downstream_bit_clock(o_downstream_bit_clock), .o_data(o_data),
	.o_downstream_frame_sync(o_downstream_frame_sync), .o_phase(o_phase), .o_slot(o_slot)
);
`default_nettype wire

// ---- dv/sspf_ref_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// receiver reference and ring data source
// ****
module sspf_ref_model #(
	parameter int		HALF_NS = 80,
	parameter realtime	START_NS = 0.0,
	parameter int		SYNC_AT = 20
) (
	input	wire logic	i_rx_level,
	output	var logic	o_clk,
	output	var logic	o_sync,
	output	var logic	o_data
);
	int	falls = 0;
	// a reference clock runs free, it never pauses between frames
	initial begin
		o_clk = 1'b0;
		o_sync = 1'b0;
		o_data = 1'b0;
		#(START_NS);
		forever #(HALF_NS) o_clk = ~o_clk;
	end
	// sync and ring data move only on the falling edge
	always @(negedge o_clk) begin
		falls <= falls + 1;
		o_sync <= (falls % 147456) >= SYNC_AT && (falls % 147456) < SYNC_AT + 32;
		o_data <= i_rx_level;
	end
endmodule // sspf_ref_model
`default_nettype wire

// ---- dv/slot_serial_port_framer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// framer bench
// ****
module slot_serial_port_framer_tb;
	logic		clk = 1'b0, srst = 1'b1, rx_level = 1'b1, own = 1'b0, add_en = 1'b0;
	logic		tx_valid = 1'b0, uf_seen = 1'b0, rs_seen = 1'b0;
	wire		resync, locked;
	logic [7:0]	tx_data = 8'h00;
	wire		up_clk, up_sync, rx_data, loc_clk, loc_sync, fwd_clk;
	wire		ds_clk, ds_sync, ds_data, tx_ready, underflow;
	wire [3:0]	phase;
	wire [4:0]	slot;
	int		err_total = 0, n_checks = 0, cycles = 0;
	sspf_ref_model u_up (.i_rx_level(rx_level), .o_clk(up_clk), .o_sync(up_sync), .o_data(rx_data));
	// local edges sit half a ns before a bench drive point, so samples never race them
	sspf_ref_model #(.START_NS(10.5), .SYNC_AT(900)) u_loc (.i_rx_level(1'b0), .o_clk(loc_clk),
		.o_sync(loc_sync), .o_data());
	sspf_framer DUT (.i_clk_sys(clk), .i_srst(srst), .i_upstream_ref_clock(up_clk),
		.i_upstream_ref_frame_sync(up_sync), .i_rx_data(rx_data), .i_local_ref_clock(loc_clk),
		.i_local_ref_frame_sync(loc_sync), .o_fwd_ref_clock(fwd_clk), .o_fwd_ref_frame_sync(),
		.o_downstream_bit_clock(ds_clk), .o_downstream_frame_sync(ds_sync), .o_data(ds_data),
		.i_ref_own(own), .i_add_en(add_en), .i_add_slot(5'h09), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_phase(phase), .o_slot(slot),
		.o_locked(locked), .o_resync(resync), .o_underflow(underflow));
	always #10 clk = ~clk;
	// hang guard and sticky underflow flag
	always @(posedge clk) begin
		cycles++;
		if (underflow === 1'b1) uf_seen <= 1'b1;
		if (resync === 1'b1) rs_seen <= 1'b1;
		if (cycles == 10000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic next_bit();
		@(negedge ds_clk);
		#1;
	endtask
	// phase ramp, slot order and sync width from the frame start
	task automatic test_frame_start();
		logic [3:0] p;
		@(posedge ds_sync);
		#1;
		for (int n = 0; n < 48; n++) begin
			p = n[3:0];
			check({4'h0, phase}, {4'h0, p});
			check({3'h0, slot}, {3'h0, {1'b0, p[0], p[1], p[2], p[3]} + 5'h01});
			check({7'h0, ds_sync}, {7'h0, n < 32});
			next_bit();
		end
		// the first reference sync cannot meet a frame wrap: restart, not lock
		check({7'h0, rs_seen}, 8'h01);
		check({7'h0, locked}, 8'h00);
		$display("frame start test done");
	endtask
	// fill the buffer, offer while full, then drain one slot until it runs dry
	task automatic test_add_slot();
		logic [24:0] got;
		got = '0;
		tx_data = 8'h5A;
		tx_valid = 1'b1;
		@(posedge clk) #1 tx_data = 8'hC3;
		@(posedge clk) #1 tx_data = 8'hFF;
		check({7'h0, tx_ready}, 8'h00);
		repeat (3) @(posedge clk) #1;
		tx_valid = 1'b0;
		add_en = 1'b1;
		uf_seen = 1'b0;
		fork
			begin
				while (tx_ready !== 1'b1) @(posedge clk) #1;
				tx_data = 8'h0F;
				tx_valid = 1'b1;
				@(posedge clk) #1 tx_valid = 1'b0;
			end
			for (int k = 0; k < 25; ) begin
				next_bit();
				if (slot == 5'h09) begin
					if (k == 24) check({7'h0, uf_seen}, 8'h00);
					got = {got[23:0], ds_data};
					k++;
				end else check({7'h0, ds_data}, 8'h01);
			end
		join
		repeat (2) @(posedge clk) #1;
		check({7'h0, uf_seen}, 8'h01);
		check(got[24:17], 8'h5A);
		check(got[16:9], 8'hC3);
		check(got[8:1], 8'h0F);
		check({7'h0, got[0]}, 8'h01);
		add_en = 1'b0;
		$display("add slot test done");
	endtask
	// substitute the own reference upstream, then return to forwarding
	task automatic test_ref_own();
		logic s;
		own = 1'b1;
		repeat (40) @(posedge clk) #1;
		s = loc_clk;
		repeat (3) @(posedge clk) #1;
		check({7'h0, fwd_clk}, {7'h0, s});
		own = 1'b0;
		repeat (400) @(posedge clk) #1;
		$display("reference select test done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 srst = 1'b0;
		test_frame_start();
		test_add_slot();
		test_ref_own();
		report_and_stop();
	end
endmodule // slot_serial_port_framer_tb
`default_nettype wire
